// File: logic/tivf_pkg.sv
package tivf_pkg;
    localparam int          CMP_MAX     = 8;
    localparam int          ADDR_W      = 32;
    localparam int          REG_AW      = 8;
    localparam logic [7:0]  OFF_CTRL    = 8'h00;
    localparam logic [7:0]  OFF_SS_SEL  = 8'h04;
    localparam logic [7:0]  OFF_PE_SEL  = 8'h08;
    localparam logic [7:0]  OFF_IE_SEL  = 8'h0c;
    localparam logic [7:0]  OFF_STATUS  = 8'h10;
    localparam logic [7:0]  OFF_RNG     = 8'h40;
    localparam logic [7:0]  OFF_RNG_END = 8'h80;
    localparam int          WIN_BIT     = 0;
    localparam int          START_LSB   = 0;
    localparam int          STOP_LSB    = 16;
    localparam int          INCL_LSB    = 0;
    localparam int          EXCL_LSB    = 16;
    localparam int          ST_VIEW     = 0;
    localparam int          ST_GAP      = 1;
    localparam logic        WIN_RST     = 1'b0;
    localparam logic        GAP_RST     = 1'b1;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        WR_IDLE = 2'b01,
        WR_RESP = 2'b10
    } tivf_wr_t;

    typedef struct packed {
        logic              valid;
        logic              exception;
        logic              el_pass;
        logic [ADDR_W-1:0] lo_addr;
        logic [ADDR_W-1:0] hi_addr;
    } tivf_blk_t;
endpackage

// File: logic/tivf_view_filter.sv
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
// Overview of operation
// - Block with starts but no stops keeps the window active throughout.
// - Stop-only block while active stays traced; window closes for the next block.
// - Block with starts and stops is active whole; points taken in program order; this design orders them by comparator number.
// - Mixed block: last point start opens next block, last stop closes it.
// - Same address as start and stop may leave the window either way.
// - Zero to eight range comparators, each include, exclude or unused; this design requires at least one.
// - Range result is included and not excluded; empty include mask includes all.
// - A range matches from lower through upper bound inclusive.
// - Any instruction inside an include range traces, however it was reached.
// - Start/stop region traces only after the start point opened the window.
// - One included instruction includes the whole block.
// - A block is excluded only when all its instructions are excluded.
// - Blocks covered only by several exclude ranges together may go either way.
// - Every block executed while the view result is high is traced.
// - After an untraced gap, the next traced block carries a trace-on marker.
// - Neighbouring low blocks may be traced; this design never does.
// - Blocks with a low view result are not traced.
// - Exceptional occurrences neither match nor update any comparator state.
// - Window state bit follows start and stop matches, held as status.
// - Separate start and stop masks select several comparators each.
module tivf_view_filter #(
    parameter int NUM_SAC = 8,
    parameter int NUM_PE  = 8,
    parameter int NUM_ARC = 8
) (
    input  wire logic                       CLK_IN,
    input  wire logic                       ARST_N_IN,
    input  wire logic [tivf_pkg::REG_AW-1:0] S_AXI_AWADDR_IN,
    input  wire logic                       S_AXI_AWVALID_IN,
    output wire logic                       S_AXI_AWREADY_OUT,
    input  wire logic [31:0]                S_AXI_WDATA_IN,
    input  wire logic [3:0]                 S_AXI_WSTRB_IN,
    input  wire logic                       S_AXI_WVALID_IN,
    output wire logic                       S_AXI_WREADY_OUT,
    output wire logic [1:0]                 S_AXI_BRESP_OUT,
    output wire logic                       S_AXI_BVALID_OUT,
    input  wire logic                       S_AXI_BREADY_IN,
    input  wire logic [tivf_pkg::REG_AW-1:0] S_AXI_ARADDR_IN,
    input  wire logic                       S_AXI_ARVALID_IN,
    output wire logic                       S_AXI_ARREADY_OUT,
    output wire logic [31:0]                S_AXI_RDATA_OUT,
    output wire logic [1:0]                 S_AXI_RRESP_OUT,
    output wire logic                       S_AXI_RVALID_OUT,
    input  wire logic                       S_AXI_RREADY_IN,
    input  wire tivf_pkg::tivf_blk_t        BLK_IN,
    input  wire logic [NUM_SAC-1:0]         SAC_HIT_IN,
    input  wire logic [NUM_PE-1:0]          PE_HIT_IN,
    output wire logic                       TRACE_BLOCK_OUT,
    output wire logic                       TRACE_ON_OUT,
    output wire logic                       VIEW_RESULT_OUT,
    output wire logic                       WINDOW_ACTIVE_OUT
);
    localparam int AW = tivf_pkg::ADDR_W;
    localparam int NP = NUM_SAC + NUM_PE;

    initial
    begin
        if (NUM_ARC > tivf_pkg::CMP_MAX || NUM_SAC < 1 || NUM_SAC > tivf_pkg::CMP_MAX
            || NUM_PE < 1 || NUM_PE > tivf_pkg::CMP_MAX || NUM_ARC < 1)
            $error("tivf_view_filter: comparator count out of range");
    end

    typedef struct packed {
        tivf_pkg::tivf_wr_t          wr;
        logic                        aw_got;
        logic                        w_got;
        logic [tivf_pkg::REG_AW-1:0] awaddr;
        logic [31:0]                 wdata;
        logic [3:0]                  wstrb;
        logic [1:0]                  bresp;
        logic                        rvalid;
        logic [31:0]                 rdata;
        logic [1:0]                  rresp;
        logic                        win;
        logic [NUM_SAC-1:0]          sac_start;
        logic [NUM_SAC-1:0]          sac_stop;
        logic [NUM_PE-1:0]           pe_start;
        logic [NUM_PE-1:0]           pe_stop;
        logic [NUM_ARC-1:0]          inc;
        logic [NUM_ARC-1:0]          exc;
        logic [NUM_ARC-1:0][AW-1:0]  lo;
        logic [NUM_ARC-1:0][AW-1:0]  hi;
        logic                        gap;
        logic                        view;
        logic                        trace;
        logic                        trace_on;
    } tivf_state_t;

    tivf_state_t s;
    tivf_state_t next_s;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
                r[b*8 +: 8] = nw[b*8 +: 8];
        end
        return r;
    endfunction

    // Highest set index plus one, zero when none is set
    function automatic logic [4:0] last_pos(input logic [15:0] v);
        logic [4:0] p;
        p = 5'h00;
        for (int i = 0; i < 16; i++)
        begin
            if (v[i])
                p = 5'(i + 1);
        end
        return p;
    endfunction

    logic              blk_go;
    logic [NP-1:0]     start_v;
    logic [NP-1:0]     stop_v;
    logic              any_start;
    logic              any_stop;
    logic              start_last;
    logic              win_blk;
    logic [NUM_ARC-1:0] arc_any;
    logic [NUM_ARC-1:0] arc_full;
    logic              incl;
    logic              excl;
    logic              view_now;
    logic              wr_fire;

    // Exceptional occurrences are not blocks: they match nothing
    assign blk_go    = BLK_IN.valid && !BLK_IN.exception;
    assign start_v   = {PE_HIT_IN & s.pe_start, SAC_HIT_IN & s.sac_start};
    assign stop_v    = {PE_HIT_IN & s.pe_stop, SAC_HIT_IN & s.sac_stop};
    assign any_start = |start_v;
    assign any_stop  = |stop_v;
    // Comparator number stands for program order only if software sorts by address
    assign start_last = last_pos(16'(start_v)) > last_pos(16'(stop_v));
    // Window must already be open or be opened inside this block
    assign win_blk   = s.win || any_start;

    always_comb
    begin
        for (int n = 0; n < NUM_ARC; n++)
        begin
            arc_any[n]  = BLK_IN.lo_addr <= s.hi[n] && BLK_IN.hi_addr >= s.lo[n];
            arc_full[n] = BLK_IN.lo_addr >= s.lo[n] && BLK_IN.hi_addr <= s.hi[n];
        end
    end

    assign incl     = |(arc_any & s.inc) || s.inc == '0;
    // Only a single covering range excludes; partial overlap keeps the block
    assign excl     = |(arc_full & s.exc);
    assign view_now = BLK_IN.el_pass && win_blk && incl && !excl;
    assign wr_fire  = s.wr == tivf_pkg::WR_IDLE && s.aw_got && s.w_got;

    always_comb
    begin
        logic [31:0] rd;
        logic [1:0]  rr;
        logic [7:0]  a;
        logic [2:0]  ix;
        rd = 32'h0000_0000;
        rr = tivf_pkg::RESP_OKAY;
        a  = 8'h00;
        ix = 3'h0;
        next_s = s;
        next_s.trace    = 1'b0;
        next_s.trace_on = 1'b0;
        if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT)
        begin
            next_s.aw_got = 1'b1;
            next_s.awaddr = S_AXI_AWADDR_IN;
        end
        if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT)
        begin
            next_s.w_got = 1'b1;
            next_s.wdata = S_AXI_WDATA_IN;
            next_s.wstrb = S_AXI_WSTRB_IN;
        end
        if (wr_fire)
        begin
            a  = s.awaddr;
            ix = a[5:3];
            next_s.wr     = tivf_pkg::WR_RESP;
            next_s.aw_got = 1'b0;
            next_s.w_got  = 1'b0;
            next_s.bresp  = tivf_pkg::RESP_OKAY;
            rd = merge(32'h0000_0000, s.wdata, s.wstrb);
            if (a == tivf_pkg::OFF_CTRL)
            begin
                if (s.wstrb[0])
                    next_s.win = rd[tivf_pkg::WIN_BIT];
            end
            else if (a == tivf_pkg::OFF_SS_SEL)
            begin
                rd = merge({8'h00, 8'(s.sac_stop), 8'h00, 8'(s.sac_start)}, s.wdata, s.wstrb);
                next_s.sac_start = rd[tivf_pkg::START_LSB +: NUM_SAC];
                next_s.sac_stop  = rd[tivf_pkg::STOP_LSB +: NUM_SAC];
            end
            else if (a == tivf_pkg::OFF_PE_SEL)
            begin
                rd = merge({8'h00, 8'(s.pe_stop), 8'h00, 8'(s.pe_start)}, s.wdata, s.wstrb);
                next_s.pe_start = rd[tivf_pkg::START_LSB +: NUM_PE];
                next_s.pe_stop  = rd[tivf_pkg::STOP_LSB +: NUM_PE];
            end
            else if (a == tivf_pkg::OFF_IE_SEL)
            begin
                rd = merge({8'h00, 8'(s.exc), 8'h00, 8'(s.inc)}, s.wdata, s.wstrb);
                next_s.inc = rd[tivf_pkg::INCL_LSB +: NUM_ARC];
                next_s.exc = rd[tivf_pkg::EXCL_LSB +: NUM_ARC];
            end
            else if (a >= tivf_pkg::OFF_RNG && a < tivf_pkg::OFF_RNG_END
                     && 32'(ix) < NUM_ARC && a[1:0] == 2'h0)
            begin
                if (a[2])
                    next_s.hi[ix] = merge(s.hi[ix], s.wdata, s.wstrb);
                else
                    next_s.lo[ix] = merge(s.lo[ix], s.wdata, s.wstrb);
            end
            else if (a != tivf_pkg::OFF_STATUS)
                next_s.bresp = tivf_pkg::RESP_SLVERR;
        end
        if (s.wr == tivf_pkg::WR_RESP && S_AXI_BREADY_IN)
            next_s.wr = tivf_pkg::WR_IDLE;
        if (s.rvalid && S_AXI_RREADY_IN)
            next_s.rvalid = 1'b0;
        if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT)
        begin
            a  = S_AXI_ARADDR_IN;
            ix = a[5:3];
            rd = 32'h0000_0000;
            if (a == tivf_pkg::OFF_CTRL)
                rd[tivf_pkg::WIN_BIT] = s.win;
            else if (a == tivf_pkg::OFF_SS_SEL)
                rd = {8'h00, 8'(s.sac_stop), 8'h00, 8'(s.sac_start)};
            else if (a == tivf_pkg::OFF_PE_SEL)
                rd = {8'h00, 8'(s.pe_stop), 8'h00, 8'(s.pe_start)};
            else if (a == tivf_pkg::OFF_IE_SEL)
                rd = {8'h00, 8'(s.exc), 8'h00, 8'(s.inc)};
            else if (a == tivf_pkg::OFF_STATUS)
            begin
                rd[tivf_pkg::ST_VIEW] = s.view;
                rd[tivf_pkg::ST_GAP]  = s.gap;
            end
            else if (a >= tivf_pkg::OFF_RNG && a < tivf_pkg::OFF_RNG_END
                     && 32'(ix) < NUM_ARC && a[1:0] == 2'h0)
                rd = a[2] ? s.hi[ix] : s.lo[ix];
            else
                rr = tivf_pkg::RESP_SLVERR;
            next_s.rvalid = 1'b1;
            next_s.rdata  = rd;
            next_s.rresp  = rr;
        end
        // Block update comes last so it wins over a software write to the window bit
        // A block with no hits leaves a same-cycle software write to the window standing
        if (blk_go)
        begin
            if (any_start && any_stop)
                next_s.win = start_last;
            else if (any_start)
                next_s.win = 1'b1;
            else if (any_stop)
                next_s.win = 1'b0;
            next_s.view     = view_now;
            next_s.trace    = view_now;
            next_s.trace_on = view_now && s.gap;
            next_s.gap      = !view_now;
        end
    end

    always_ff @(posedge CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            s     <= '0;
            s.wr  <= tivf_pkg::WR_IDLE;
            s.win <= tivf_pkg::WIN_RST;
            s.gap <= tivf_pkg::GAP_RST;
        end
        else
            s <= next_s;
    end

    assign S_AXI_AWREADY_OUT = s.wr == tivf_pkg::WR_IDLE && !s.aw_got;
    assign S_AXI_WREADY_OUT  = s.wr == tivf_pkg::WR_IDLE && !s.w_got;
    assign S_AXI_BVALID_OUT  = s.wr == tivf_pkg::WR_RESP;
    assign S_AXI_BRESP_OUT   = s.bresp;
    assign S_AXI_ARREADY_OUT = !s.rvalid;
    assign S_AXI_RVALID_OUT  = s.rvalid;
    assign S_AXI_RDATA_OUT   = s.rdata;
    assign S_AXI_RRESP_OUT   = s.rresp;
    assign TRACE_BLOCK_OUT   = s.trace;
    assign TRACE_ON_OUT      = s.trace_on;
    assign VIEW_RESULT_OUT   = s.view;
    assign WINDOW_ACTIVE_OUT = s.win;

    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!ARST_N_IN);

    start_only_win_a: assert property (
        blk_go && any_start && !any_stop |=> WINDOW_ACTIVE_OUT)
        else $error("window not open after start-only block");

    stop_only_close_a: assert property (
        blk_go && s.win && any_stop && !any_start && BLK_IN.el_pass && incl && !excl
        |=> VIEW_RESULT_OUT && !WINDOW_ACTIVE_OUT)
        else $error("stop-only block mishandled");

    mixed_last_a: assert property (
        blk_go && any_start && any_stop |=> WINDOW_ACTIVE_OUT == $past(start_last))
        else $error("mixed block left wrong window state");

    mixed_whole_a: assert property (
        blk_go && any_start && any_stop && BLK_IN.el_pass && incl && !excl
        |=> TRACE_BLOCK_OUT)
        else $error("mixed block not traced whole");

    excep_frozen_a: assert property (
        BLK_IN.valid && BLK_IN.exception && !wr_fire
        |=> $stable(WINDOW_ACTIVE_OUT) && !TRACE_BLOCK_OUT)
        else $error("exception touched filter state");

    incl_block_a: assert property (
        blk_go && BLK_IN.el_pass && win_blk && |(arc_any & s.inc) && !excl
        |=> TRACE_BLOCK_OUT)
        else $error("included block not traced");

    excl_block_a: assert property (
        blk_go && |(arc_full & s.exc) |=> !TRACE_BLOCK_OUT)
        else $error("fully excluded block traced");

    empty_incl_a: assert property (
        blk_go && s.inc == '0 && s.exc == '0 && BLK_IN.el_pass && win_blk
        |=> TRACE_BLOCK_OUT)
        else $error("empty include mask blocked trace");

    range_edge_a: assert property (
        BLK_IN.lo_addr == s.hi[0] && BLK_IN.hi_addr == s.hi[0] && s.lo[0] <= s.hi[0]
        |-> arc_any[0] && arc_full[0])
        else $error("range upper bound not inclusive");

    // A low last view means nothing was traced since, so a gap is pending
    trace_on_gap_a: assert property (
        blk_go && view_now && !VIEW_RESULT_OUT |=> TRACE_ON_OUT && TRACE_BLOCK_OUT)
        else $error("trace-on missing after gap");

    // Blocks may arrive back to back, so only the cycle after the block is judged
    view_trace_a: assert property (
        blk_go && view_now |=> TRACE_BLOCK_OUT && VIEW_RESULT_OUT)
        else $error("high view block not traced");

    idle_no_trace_a: assert property (
        !blk_go |=> !TRACE_BLOCK_OUT && !TRACE_ON_OUT)
        else $error("trace without a block");

    no_start_closed_a: assert property (
        blk_go && !s.win && !any_start && !wr_fire
        |=> !TRACE_BLOCK_OUT && !WINDOW_ACTIVE_OUT)
        else $error("traced without start point");

    mixed_c: cover property (blk_go && any_start && any_stop && view_now);
    gap_c:   cover property (TRACE_ON_OUT);
    excl_c:  cover property (blk_go && excl && win_blk);
    exc_c:   cover property (BLK_IN.valid && BLK_IN.exception && s.win);
    edge_c:  cover property (blk_go && BLK_IN.lo_addr == s.hi[0]);
endmodule

// File: bench/tivf_core_model.sv
`timescale 1ns/1ns
module tivf_core_model #(
    parameter int NUM_SAC = 8,
    parameter int NUM_PE  = 8
) (
    input  wire logic                clk_in,
    output tivf_pkg::tivf_blk_t      blk_out,
    output logic [NUM_SAC-1:0]       sac_out,
    output logic [NUM_PE-1:0]        pe_out
);
    initial
    begin
        blk_out = '0;
        sac_out = '0;
        pe_out  = '0;
    end

    // Hit bits follow comparator number; the bench programs ascending addresses
    task put(input logic exc, el, input logic [31:0] lo, hi,
             input logic [NUM_SAC-1:0] s, input logic [NUM_PE-1:0] p);
        begin
            blk_out <= '{1'b1, exc, el, lo, hi};
            sac_out <= s;
            pe_out  <= p;
            @(posedge clk_in);
            // One edge per block, so a slow caller never repeats it
            blk_out.valid <= 1'b0;
        end
    endtask

    // Idle lines toggle so a stale block never looks valid by accident
    task rest();
        begin
            blk_out <= '{1'b0, ~blk_out.exception, ~blk_out.el_pass,
                         ~blk_out.lo_addr, ~blk_out.hi_addr};
            sac_out <= ~sac_out;
            pe_out  <= ~pe_out;
            @(posedge clk_in);
        end
    endtask
endmodule

// File: bench/trace_instr_view_filter_tb.sv
`timescale 1ns/1ns
module trace_instr_view_filter_tb;
    localparam logic [31:0] A0 = 32'h0000_1000;
    localparam logic [31:0] A1 = 32'h0000_100c;
    logic                clk;
    logic                arst_n;
    logic [7:0]          awaddr, araddr;
    logic [31:0]         wdata;
    logic [3:0]          wstrb;
    logic                awvalid, wvalid, bready, arvalid, rready;
    wire logic           awready, wready, bvalid, arready, rvalid;
    wire logic           trace, tr_on, view, win;
    wire logic [1:0]     bresp, rresp;
    wire logic [31:0]    rdata;
    wire tivf_pkg::tivf_blk_t blk;
    wire logic [7:0]     single_addr_comparator, pe;
    int                  bad_count, check_count;

    tivf_view_filter u_dut (
        .CLK_IN(clk), .ARST_N_IN(arst_n),
        .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
        .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid),
        .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
        .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
        .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
        .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready), .BLK_IN(blk),
        .SAC_HIT_IN(single_addr_comparator), .PE_HIT_IN(pe), .TRACE_BLOCK_OUT(trace), .TRACE_ON_OUT(tr_on),
        .VIEW_RESULT_OUT(view), .WINDOW_ACTIVE_OUT(win)
    );

    tivf_core_model u_core (.clk_in(clk), .blk_out(blk), .sac_out(single_addr_comparator), .pe_out(pe));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task check(input logic [31:0] seen, exp);
        begin
            check_count++;
            if (seen !== exp)
            begin
                bad_count++;
                $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    task end_of_test();
        begin
            if (bad_count == 0 && check_count > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask

    // Sample readies at the falling edge; they only move on rising edges
    task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int          n;
        logic        pa, pw, ta, tw, got;
        logic [1:0]  rsp;
        begin
            pa = 1'b1;
            pw = 1'b1;
            got = 1'b0;
            rsp = 2'h3;
            @(posedge clk);
            awaddr <= a;
            awvalid <= 1'b1;
            wdata <= d;
            wvalid <= 1'b1;
            bready <= 1'b1;
            for (n = 0; n < 40 && (pa || pw); n++)
            begin
                @(negedge clk);
                ta = pa && awready;
                tw = pw && wready;
                @(posedge clk);
                if (ta) awvalid <= 1'b0;
                if (tw) wvalid <= 1'b0;
                pa = pa && !ta;
                pw = pw && !tw;
            end
            for (n = 0; n < 40 && !got; n++)
            begin
                @(negedge clk);
                got = bvalid;
                rsp = bresp;
                @(posedge clk);
            end
            bready <= 1'b0;
            check(rsp, er);
        end
    endtask

    task axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int          n;
        logic        got;
        logic [31:0] d;
        logic [1:0]  rsp;
        begin
            got = 1'b0;
            d = '1;
            rsp = 2'h3;
            @(posedge clk);
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            for (n = 0; n < 40 && !got; n++)
            begin
                @(negedge clk);
                got = arready;
                @(posedge clk);
            end
            arvalid <= 1'b0;
            got = 1'b0;
            for (n = 0; n < 40 && !got; n++)
            begin
                @(negedge clk);
                got = rvalid;
                rsp = rresp;
                d = rdata;
                @(posedge clk);
            end
            rready <= 1'b0;
            check(d, ed);
            check(rsp, er);
        end
    endtask

    task blk_chk(input logic exc, el, input logic [31:0] lo, hi, input logic [7:0] s, p,
                 input logic et, eo, ev, ew);
        begin
            u_core.put(exc, el, lo, hi, s, p);
            @(negedge clk);
            check(trace, et);
            check(tr_on, eo);
            check(view, ev);
            check(win, ew);
            @(posedge clk);
        end
    endtask

    task test_regs();
        begin
            axi_rd(tivf_pkg::OFF_CTRL, 32'h0, tivf_pkg::RESP_OKAY);
            axi_rd(tivf_pkg::OFF_SS_SEL, 32'h0, tivf_pkg::RESP_OKAY);
            axi_rd(tivf_pkg::OFF_STATUS, 32'h1 << tivf_pkg::ST_GAP, tivf_pkg::RESP_OKAY);
            axi_wr(tivf_pkg::OFF_STATUS, 32'h1, tivf_pkg::RESP_OKAY);
            axi_rd(tivf_pkg::OFF_STATUS, 32'h1 << tivf_pkg::ST_GAP, tivf_pkg::RESP_OKAY);
            axi_rd(8'h14, 32'h0, tivf_pkg::RESP_SLVERR);
            axi_wr(tivf_pkg::OFF_RNG_END, 32'h5, tivf_pkg::RESP_SLVERR);
            axi_wr(8'h02, 32'h5, tivf_pkg::RESP_SLVERR);
            axi_wr(8'h78, 32'h0000_040c, tivf_pkg::RESP_OKAY);
            axi_rd(8'h78, 32'h0000_040c, tivf_pkg::RESP_OKAY);
        end
    endtask

    // Starts on SINGLE_ADDR_COMPARATOR 0 and 2, stop on SINGLE_ADDR_COMPARATOR 1; core input 0 starts, 1 stops
    task test_start_stop();
        begin
            axi_wr(tivf_pkg::OFF_SS_SEL, (32'h2 << tivf_pkg::STOP_LSB) | 32'h5, 2'h0);
            axi_wr(tivf_pkg::OFF_PE_SEL, (32'h2 << tivf_pkg::STOP_LSB) | 32'h1, 2'h0);
            blk_chk(0, 1, A0, A1, 8'h00, 8'h00, 0, 0, 0, 0);
            blk_chk(0, 1, A0, A1, 8'h01, 8'h00, 1, 1, 1, 1);
            blk_chk(0, 1, A0, A1, 8'h00, 8'h00, 1, 0, 1, 1);
            blk_chk(0, 1, A0, A1, 8'h02, 8'h00, 1, 0, 1, 0);
            blk_chk(0, 1, A0, A1, 8'h00, 8'h00, 0, 0, 0, 0);
            blk_chk(1, 1, A0, A1, 8'h01, 8'h00, 0, 0, 0, 0);
            blk_chk(0, 1, A0, A1, 8'h03, 8'h00, 1, 1, 1, 0);
            blk_chk(0, 1, A0, A1, 8'h06, 8'h00, 1, 0, 1, 1);
            blk_chk(0, 1, A0, A1, 8'h03, 8'h00, 1, 0, 1, 0);
            blk_chk(0, 1, A0, A1, 8'h02, 8'h01, 1, 0, 1, 1);
            blk_chk(0, 1, A0, A1, 8'h00, 8'h02, 1, 0, 1, 0);
            blk_chk(0, 0, A0, A1, 8'h01, 8'h00, 0, 0, 0, 1);
            blk_chk(0, 1, A0, A1, 8'h00, 8'h00, 1, 1, 1, 1);
            u_core.rest();
            axi_rd(tivf_pkg::OFF_STATUS, 32'h1 << tivf_pkg::ST_VIEW, 2'h0);
            axi_wr(tivf_pkg::OFF_CTRL, 32'h0, 2'h0);
            axi_rd(tivf_pkg::OFF_CTRL, 32'h0, 2'h0);
        end
    endtask

    // Range 0 spans 0x100..0x1ff, range 1 spans 0x180..0x1bf; window held open
    task test_ranges();
        begin
            axi_wr(tivf_pkg::OFF_CTRL, 32'h1, 2'h0);
            axi_wr(tivf_pkg::OFF_RNG, 32'h100, 2'h0);
            axi_wr(8'h44, 32'h1ff, 2'h0);
            axi_wr(8'h48, 32'h180, 2'h0);
            axi_wr(8'h4c, 32'h1bf, 2'h0);
            axi_wr(tivf_pkg::OFF_IE_SEL, 32'h1, 2'h0);
            blk_chk(0, 1, 32'h200, 32'h20f, 8'h00, 8'h00, 0, 0, 0, 1);
            blk_chk(0, 1, 32'h1ff, 32'h20f, 8'h00, 8'h00, 1, 1, 1, 1);
            blk_chk(0, 1, 32'h1ff, 32'h1ff, 8'h00, 8'h00, 1, 0, 1, 1);
            blk_chk(0, 1, 32'h0f0, 32'h100, 8'h00, 8'h00, 1, 0, 1, 1);
            blk_chk(0, 1, 32'h150, 32'h160, 8'h00, 8'h00, 1, 0, 1, 1);
            u_core.rest();
            axi_wr(tivf_pkg::OFF_IE_SEL, (32'h2 << tivf_pkg::EXCL_LSB) | 32'h1, 2'h0);
            blk_chk(0, 1, 32'h180, 32'h1bf, 8'h00, 8'h00, 0, 0, 0, 1);
            blk_chk(0, 1, 32'h17c, 32'h180, 8'h00, 8'h00, 1, 1, 1, 1);
            u_core.rest();
            axi_wr(tivf_pkg::OFF_IE_SEL, 32'h2 << tivf_pkg::EXCL_LSB, 2'h0);
            blk_chk(0, 1, 32'h300, 32'h30f, 8'h00, 8'h00, 1, 0, 1, 1);
            blk_chk(0, 1, 32'h190, 32'h1a0, 8'h00, 8'h00, 0, 0, 0, 1);
            blk_chk(1, 1, 32'h300, 32'h30f, 8'h00, 8'h00, 0, 0, 0, 1);
            u_core.rest();
        end
    endtask

    initial
    begin
        bad_count = 0;
        check_count = 0;
        arst_n = 1'b0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = 4'hf;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        test_regs();
        test_start_stop();
        test_ranges();
        end_of_test();
    end

    initial
    begin
        #100000;
        bad_count++;
        end_of_test();
    end
endmodule
